// ### addr_map_checker.sv
`default_nettype none
module addr_map_checker #(
  parameter int ROM_64K = 1
) (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        place_valid_i,
  input wire logic        place_high_i,
  input wire logic        ext_mode_en_i,
  input wire logic        acc_valid_i,
  input wire logic [19:0] acc_addr_i,
  input wire logic [1:0]  acc_width_i,
  input wire logic        acc_vec_i,
  input wire logic        pc_load_i,
  input wire logic [2:0]  pc_step_i,
  input wire logic        ready_o,
  input wire logic        placed_o,
  input wire logic        high_o,
  input wire logic        place_err_o,
  input wire logic        sel_rom_o,
  input wire logic        sel_ram_o,
  input wire logic        sel_gpr_o,
  input wire logic        sel_sfr_o,
  input wire logic        sel_ext_o,
  input wire logic        sel_none_o,
  input wire logic        vec_area_o,
  input wire logic        table_indexed_call_area_o,
  input wire logic        short_form_call_area_o,
  input wire logic        data_area_o,
  input wire logic        sfr_err_o,
  input wire logic        lockup_o,
  input wire logic [19:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // helper terms
  // ------------
  // placement strobe excluded so the segment in use is settled
  wire logic       take = acc_valid_i & ready_o & ~lockup_o & ~place_valid_i;
  wire logic [3:0] seg  = high_o ? 4'hf : 4'h0;
  wire logic       win  = take & ~acc_vec_i & (acc_addr_i[19:16] == seg);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------
  // properties
  // ------------
  place_take_a: assert property (!placed_o && place_valid_i |=> placed_o &&
    high_o == $past(place_high_i)) else $error("placement not taken");
  place_once_a: assert property (placed_o && place_valid_i |=> place_err_o &&
    $stable(high_o)) else $error("repeated placement not refused");
  ext_gate_a: assert property (sel_ext_o |-> $past(ext_mode_en_i))
    else $error("external select while expansion off");
  vec_area_a: assert property (take && acc_addr_i[19:6] == 14'h0 |=>
    sel_rom_o && vec_area_o) else $error("vector area decode wrong");
  table_indexed_call_area_a: assert property (take && acc_addr_i[19:6] == 14'h1 |=>
    sel_rom_o && table_indexed_call_area_o) else $error("table call area decode wrong");
  short_form_call_area_a: assert property (take && acc_addr_i[19:11] == 9'h1 |=>
    sel_rom_o && short_form_call_area_o) else $error("short call area decode wrong");
  rom_high_a: assert property (take && ROM_64K != 0 && high_o &&
    acc_addr_i[19:12] == 8'h0f && acc_addr_i[11:8] >= 4'h7 |=> sel_rom_o)
    else $error("overlap rom not usable under high placement");
  data_area_a: assert property (win && acc_addr_i[15:8] == 8'hfd |=>
    sel_ram_o && data_area_o) else $error("data area decode wrong");
  sfr_win_a: assert property (win && acc_addr_i[15:8] == 8'hff |=>
    !(sel_rom_o || sel_ram_o || sel_gpr_o || sel_ext_o || sel_none_o))
    else $error("special window decoded elsewhere");
  lock_hold_a: assert property (lockup_o && acc_valid_i |=> lockup_o &&
    !(sel_rom_o || sel_sfr_o || sel_ram_o)) else $error("request served in lockup");
  odd_word_a: assert property (win && acc_addr_i[15:4] == 12'hff1 &&
    acc_addr_i[0] && acc_addr_i[3:0] != 4'hf && acc_width_i == 2'h2 |=> sfr_err_o)
    else $error("odd word access accepted");
  pc_step_a: assert property ($past(reset_n_i) && !$past(pc_load_i) |->
    pc_o == 20'($past(pc_o) + $past(pc_step_i))) else $error("pc did not step");
  cover property (placed_o && place_valid_i);
  cover property ($rose(lockup_o));
  cover property (take && acc_width_i == 2'h2);
endmodule

bind addr_map_cpu_regs addr_map_checker #(.ROM_64K(ROM_64K)) addr_map_checker_i (.*);
`default_nettype wire

// ### addr_map_cpu_regs.v
`default_nettype none

module addr_map_cpu_regs #(
  parameter ROM_64K = 1
) (
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire        place_valid_i,
  input  wire        place_high_i,
  input  wire        ext_mode_en_i,
  input  wire        acc_valid_i,
  input  wire [19:0] acc_addr_i,
  input  wire        acc_write_i,
  input  wire [1:0]  acc_width_i,
  input  wire [2:0]  acc_bit_i,
  input  wire [15:0] acc_wdata_i,
  input  wire        acc_vec_i,
  input  wire [3:0]  gpr_rd_idx_i,
  input  wire        gpr_rd_pair_i,
  input  wire        gpr_we_i,
  input  wire [3:0]  gpr_wr_idx_i,
  input  wire        gpr_wr_pair_i,
  input  wire [15:0] gpr_wdata_i,
  input  wire        alias_en_i,
  input  wire [2:0]  alias_code_i,
  input  wire [1:0]  ptr_sel_i,
  input  wire        ext_we_i,
  input  wire [1:0]  ext_sel_i,
  input  wire [7:0]  ext_wdata_i,
  input  wire        ctx_bank_we_i,
  input  wire [2:0]  ctx_bank_i,
  input  wire        pc_load_i,
  input  wire [19:0] pc_val_i,
  input  wire [2:0]  pc_step_i,
  input  wire        psw_we_i,
  input  wire [15:0] psw_wdata_i,
  input  wire        sp_we_i,
  input  wire [23:0] sp_wdata_i,
  output reg         ready_o,
  output reg         placed_o,
  output reg         high_o,
  output reg         place_err_o,
  output reg         sel_rom_o,
  output reg         sel_ram_o,
  output reg         sel_gpr_o,
  output reg         sel_sfr_o,
  output reg         sel_ext_o,
  output reg         sel_none_o,
  output reg         vec_area_o,
  output reg         table_indexed_call_area_o,
  output reg         short_form_call_area_o,
  output reg         data_area_o,
  output reg  [15:0] local_addr_o,
  output reg         sfr_err_o,
  output reg         lockup_o,
  output reg  [15:0] sfr_rdata_o,
  output reg  [15:0] gpr_rdata_o,
  output reg  [23:0] ptr_o,
  output reg  [19:0] gpr_ram_addr_o,
  output reg  [19:0] pc_o,
  output reg  [15:0] psw_o,
  output reg  [23:0] sp_o
);

  `include "addr_map_defs.vh"

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [7:0]  gpr_mem [0:127];
  reg  [7:0]  sfr_mem [0:255];
  reg  [7:0]  ext_reg [0:3];
  reg  [7:0]  init_cnt_q;
  wire [2:0]  bank    = psw_o[`PSW_BANK_MSB:`PSW_BANK_LSB];
  wire        alias_on = alias_en_i & psw_o[`PSW_ALIAS_BIT];

  // ----------------------------------------------------------------------
  // attribute lookups: one for the access port, one for the init walk
  // ----------------------------------------------------------------------
  wire        a_alloc;
  wire        a_rd;
  wire        a_wr;
  wire        a_bit;
  wire        a_byte;
  wire        a_word;
  wire [7:0]  i_rst;

  sfr_attr_table u_attr_acc (
    .off_i   (acc_addr_i[7:0]),
    .alloc_o (a_alloc),
    .rd_o    (a_rd),
    .wr_o    (a_wr),
    .bit_o   (a_bit),
    .byte_o  (a_byte),
    .word_o  (a_word),
    .rst_o   ()
  );

  sfr_attr_table u_attr_init (
    .off_i   (init_cnt_q),
    .alloc_o (),
    .rd_o    (),
    .wr_o    (),
    .bit_o   (),
    .byte_o  (),
    .word_o  (),
    .rst_o   (i_rst)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  reg  [3:0]  data_seg;
  reg  [15:0] rom_top;
  reg         in_data;
  reg         in_rom;
  reg         phys_rom;
  reg  [2:0]  dec;
  localparam [2:0] D_NONE = 3'h0, D_ROM = 3'h1, D_RAM = 3'h2, D_GPR = 3'h3,
                   D_SFR  = 3'h4, D_EXT = 3'h5;

  always @* begin
    data_seg = high_o ? `AM_SEG_HIGH : `AM_SEG_LOW;
    in_data  = (acc_addr_i[19:16] == data_seg) &&
               (acc_addr_i[15:0] >= `AM_IDATA_BASE);
    // 64K part loses the overlap only under low placement
    if (ROM_64K != 0) begin
      rom_top = high_o ? `AM_ROM64_HIGH_END : `AM_ROM64_LOW_END;
    end else begin
      rom_top = `AM_ROM48_END;
    end
    phys_rom = (acc_addr_i[19:16] == 4'h0) &&
               ((ROM_64K != 0) || (acc_addr_i[15:0] <= `AM_ROM48_END));
    in_rom   = (acc_addr_i[19:16] == 4'h0) && (acc_addr_i[15:0] <= rom_top);
    if (acc_vec_i && phys_rom) begin
      dec = D_ROM;
    end else if (in_data) begin
      if (acc_addr_i[15:0] >= `AM_SFR_BASE) begin
        dec = D_SFR;
      end else if (acc_addr_i[15:0] >= `AM_GPR_BASE) begin
        dec = D_GPR;
      end else begin
        dec = D_RAM;
      end
    end else if (in_rom) begin
      dec = D_ROM;
    end else if (ext_mode_en_i) begin
      dec = D_EXT;
    end else begin
      dec = D_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // special register access check
  // ----------------------------------------------------------------------
  reg         sfr_ok;
  always @* begin
    case (acc_width_i)
      `AW_BIT:  sfr_ok = a_bit;
      `AW_BYTE: sfr_ok = a_byte;
      `AW_WORD: sfr_ok = a_word & ~acc_addr_i[0];
      default:  sfr_ok = 1'b0;
    endcase
    sfr_ok = sfr_ok & (acc_write_i ? a_wr : a_rd);
  end

  // ----------------------------------------------------------------------
  // placement state
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      placed_o    <= 1'b0;
      high_o      <= 1'b0;
      place_err_o <= 1'b0;
    end else begin
      place_err_o <= 1'b0;
      if (place_valid_i) begin
        if (!placed_o) begin
          placed_o <= 1'b1;
          high_o   <= place_high_i;
        end else begin
          place_err_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // decode result and special register access, one cycle after request
  // ----------------------------------------------------------------------
  wire        take = acc_valid_i & ready_o & ~lockup_o;
  wire [7:0]  off  = acc_addr_i[7:0];
  wire [7:0]  offh = {acc_addr_i[7:1], 1'b1};

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sel_rom_o    <= 1'b0;
      sel_ram_o    <= 1'b0;
      sel_gpr_o    <= 1'b0;
      sel_sfr_o    <= 1'b0;
      sel_ext_o    <= 1'b0;
      sel_none_o   <= 1'b0;
      vec_area_o   <= 1'b0;
      table_indexed_call_area_o <= 1'b0;
      short_form_call_area_o <= 1'b0;
      data_area_o  <= 1'b0;
      local_addr_o <= 16'h0000;
      sfr_err_o    <= 1'b0;
      lockup_o     <= 1'b0;
      sfr_rdata_o  <= 16'h0000;
    end else begin
      sel_rom_o  <= take && (dec == D_ROM);
      sel_ram_o  <= take && (dec == D_RAM);
      sel_gpr_o  <= take && (dec == D_GPR);
      sel_sfr_o  <= take && (dec == D_SFR) && a_alloc && sfr_ok;
      sel_ext_o  <= take && (dec == D_EXT);
      sel_none_o <= take && (dec == D_NONE);
      sfr_err_o  <= take && (dec == D_SFR) && a_alloc && !sfr_ok;
      // areas carved out of the base of ROM, then the data area in RAM and general registers
      vec_area_o   <= take && (dec == D_ROM) &&
                      (acc_addr_i[15:0] <= `AM_VEC_END);
      table_indexed_call_area_o <= take && (dec == D_ROM) &&
                      (acc_addr_i[15:0] >= `AM_TABLE_INDEXED_CALL_BASE) &&
                      (acc_addr_i[15:0] <= `AM_TABLE_INDEXED_CALL_END);
      short_form_call_area_o <= take && (dec == D_ROM) &&
                      (acc_addr_i[15:0] >= `AM_SHORT_FORM_CALL_BASE) &&
                      (acc_addr_i[15:0] <= `AM_SHORT_FORM_CALL_END);
      data_area_o  <= take && (dec == D_RAM || dec == D_GPR) &&
                      (acc_addr_i[15:0] >= `AM_DATA_BASE);
      if (take) begin
        local_addr_o <= (dec == D_RAM || dec == D_GPR) ?
                        (acc_addr_i[15:0] - `AM_IDATA_BASE) : acc_addr_i[15:0];
      end
      // an unallocated hole hangs the bus; nothing but reset frees it
      if (take && (dec == D_SFR) && !a_alloc) begin
        lockup_o <= 1'b1;
      end
      if (take && (dec == D_SFR) && a_alloc && sfr_ok && !acc_write_i) begin
        case (acc_width_i)
          `AW_BIT:  sfr_rdata_o <= {15'h0000, sfr_mem[off][acc_bit_i]};
          `AW_WORD: sfr_rdata_o <= {sfr_mem[offh], sfr_mem[off]};
          default:  sfr_rdata_o <= {8'h00, sfr_mem[off]};
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // special register storage: reset walk, then writes from the port
  // ----------------------------------------------------------------------
  // the walk costs 256 cycles after reset; ready_o gates the first fetch
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      init_cnt_q <= 8'h00;
      ready_o    <= 1'b0;
    end else if (!ready_o) begin
      sfr_mem[init_cnt_q] <= i_rst;
      init_cnt_q          <= init_cnt_q + 8'h01;
      if (init_cnt_q == `SFR_INIT_LAST) begin
        ready_o <= 1'b1;
      end
    end else if (take && (dec == D_SFR) && a_alloc && sfr_ok && acc_write_i) begin
      case (acc_width_i)
        `AW_BIT: begin
          sfr_mem[off][acc_bit_i] <= acc_wdata_i[0];
        end
        `AW_WORD: begin
          sfr_mem[off]  <= acc_wdata_i[7:0];
          sfr_mem[offh] <= acc_wdata_i[15:8];
        end
        default: begin
          sfr_mem[off] <= acc_wdata_i[7:0];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // general register index mapping, with legacy names
  // ----------------------------------------------------------------------
  // codes: 0..3 single registers, 4..5 pairs
  function [4:0] alias_map;
    input [2:0] code;
    begin
      case (code)
        3'h0:    alias_map = 5'h04;
        3'h1:    alias_map = 5'h05;
        3'h2:    alias_map = 5'h06;
        3'h3:    alias_map = 5'h07;
        3'h4:    alias_map = 5'h14;
        3'h5:    alias_map = 5'h16;
        default: alias_map = 5'h04;
      endcase
    end
  endfunction

  wire [4:0] am       = alias_map(alias_code_i);
  wire [3:0] rd_idx   = alias_on ? am[3:0] : gpr_rd_idx_i;
  wire       rd_pair  = alias_on ? am[4] : gpr_rd_pair_i;
  wire [3:0] wr_idx   = alias_on ? am[3:0] : gpr_wr_idx_i;
  wire       wr_pair  = alias_on ? am[4] : gpr_wr_pair_i;
  wire [6:0] rd_lo    = {bank, rd_idx[3:1], rd_pair ? 1'b0 : rd_idx[0]};
  wire [6:0] rd_hi    = {bank, rd_idx[3:1], 1'b1};
  wire [6:0] wr_lo    = {bank, wr_idx[3:1], wr_pair ? 1'b0 : wr_idx[0]};
  wire [6:0] wr_hi    = {bank, wr_idx[3:1], 1'b1};
  wire [6:0] ptr_lo   = {bank, 1'b1, ptr_sel_i, 1'b0};
  wire [6:0] ptr_hi   = {bank, 1'b1, ptr_sel_i, 1'b1};

  // ----------------------------------------------------------------------
  // general registers: bytes, pairs and extended pointers
  // ----------------------------------------------------------------------
  // storage follows the bank index, so a switch copies nothing
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      gpr_rdata_o    <= 16'h0000;
      ptr_o          <= 24'h000000;
      gpr_ram_addr_o <= {`AM_SEG_LOW, `AM_GPR_BASE};
    end else begin
      if (gpr_we_i) begin
        gpr_mem[wr_lo] <= gpr_wdata_i[7:0];
        if (wr_pair) begin
          gpr_mem[wr_hi] <= gpr_wdata_i[15:8];
        end
      end
      if (ext_we_i) begin
        ext_reg[ext_sel_i] <= ext_wdata_i;
      end
      gpr_rdata_o <= rd_pair ? {gpr_mem[rd_hi], gpr_mem[rd_lo]} :
                               {8'h00, gpr_mem[rd_lo]};
      ptr_o <= {ext_reg[ptr_sel_i], gpr_mem[ptr_hi], gpr_mem[ptr_lo]};
      gpr_ram_addr_o <= {data_seg, `AM_GPR_BASE + {5'h00, rd_lo, 4'h0} -
                         {5'h00, rd_lo, 4'h0} + {9'h000, rd_lo}};
    end
  end

  // ----------------------------------------------------------------------
  // program counter, status word, stack pointer
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pc_o  <= `PC_RST;
      psw_o <= `PSW_RST;
      sp_o  <= `SP_RST;
    end else begin
      if (pc_load_i) begin
        pc_o <= pc_val_i;
      end else begin
        pc_o <= pc_o + {17'h00000, pc_step_i};
      end
      // a context switch takes the bank field over a software write
      if (psw_we_i) begin
        psw_o <= psw_wdata_i;
      end
      if (ctx_bank_we_i) begin
        psw_o[`PSW_BANK_MSB:`PSW_BANK_LSB] <= ctx_bank_i;
      end
      // top nibble is software's to keep clear; stored as written
      if (sp_we_i) begin
        sp_o <= sp_wdata_i;
      end
    end
  end

endmodule

`default_nettype wire

// ### addr_map_cpu_regs_tb.sv
`default_nettype none
module addr_map_cpu_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // signals
  // ------------
  logic        ref_clk_i = '0, reset_n_i = '0, place_valid_i = '0, place_high_i = '0;
  logic        ext_mode_en_i = '0, acc_valid_i = '0, acc_write_i = '0, acc_vec_i = '0;
  logic        gpr_rd_pair_i = '0, gpr_we_i = '0, gpr_wr_pair_i = '0, alias_en_i = '0;
  logic        ext_we_i = '0, ctx_bank_we_i = '0, pc_load_i = '0, psw_we_i = '0, sp_we_i = '0;
  logic [19:0] acc_addr_i = '0, pc_val_i = '0;
  logic [15:0] acc_wdata_i = '0, gpr_wdata_i = '0, psw_wdata_i = '0;
  logic [23:0] sp_wdata_i = '0;
  logic [7:0]  ext_wdata_i = '0;
  logic [3:0]  gpr_rd_idx_i = '0, gpr_wr_idx_i = '0;
  logic [2:0]  acc_bit_i = '0, alias_code_i = '0, ctx_bank_i = '0, pc_step_i = '0;
  logic [1:0]  acc_width_i = '0, ptr_sel_i = '0, ext_sel_i = '0;
  logic        ready_o, placed_o, high_o, place_err_o, sel_rom_o, sel_ram_o, sel_gpr_o;
  logic        sel_sfr_o, sel_ext_o, sel_none_o, vec_area_o, table_indexed_call_area_o, short_form_call_area_o;
  logic        data_area_o, sfr_err_o, lockup_o;
  logic [15:0] local_addr_o, sfr_rdata_o, gpr_rdata_o, psw_o;
  logic [23:0] ptr_o, sp_o;
  logic [19:0] gpr_ram_addr_o, pc_o;
  int          err_total = 0, check_count = 0;
  wire  [5:0]  sel = {sel_rom_o, sel_ram_o, sel_gpr_o, sel_sfr_o, sel_ext_o, sel_none_o};
  // 64-Kbyte variant, the one with the overlap rom
  addr_map_cpu_regs #(.ROM_64K(1)) addr_map_cpu_regs_i (.*);
  // 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;
  // ------------
  // helpers
  // ------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc;
    @(posedge ref_clk_i);
    #1;
  endtask
  // one request; returns while the answer pulse stands
  task automatic acc(input logic [19:0] a, input logic w, input logic [1:0] wd,
                     input logic [15:0] d);
    cyc;
    acc_addr_i = a;
    acc_write_i = w;
    acc_width_i = wd;
    acc_wdata_i = d;
    acc_valid_i = 1'h1;
    cyc;
    acc_valid_i = 1'h0;
  endtask
  task automatic wr(input logic [3:0] i, input logic p, input logic [15:0] d);
    cyc;
    gpr_wr_idx_i = i;
    gpr_wr_pair_i = p;
    gpr_wdata_i = d;
    gpr_we_i = 1'h1;
    cyc;
    gpr_we_i = 1'h0;
  endtask
  // read data is registered, so it shows one edge after the index
  task automatic rd(input logic [3:0] i, input logic p);
    cyc;
    gpr_rd_idx_i = i;
    gpr_rd_pair_i = p;
    cyc;
  endtask
  task automatic pw(input logic [15:0] d);
    cyc;
    psw_wdata_i = d;
    psw_we_i = 1'h1;
    cyc;
    psw_we_i = 1'h0;
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic t_reset;
    int n;
    n = 0;
    chk({ready_o, lockup_o, placed_o, psw_o, gpr_ram_addr_o[15:0]}, {19'h0, 16'hfe80});
    while (ready_o !== 1'h1 && n < 300) begin
      cyc;
      n++;
    end
    chk(n[23:0], 24'h100);
    if (n == 300) end_sim;
    acc(20'h0ff20, 1'h0, 2'h1, 16'h0);
    chk({sel, sfr_rdata_o}, {6'h04, 16'h00ff});
    acc(20'h0ff30, 1'h0, 2'h1, 16'h0);
    chk(sfr_rdata_o, 16'h0010);
    acc(20'h0ff06, 1'h0, 2'h1, 16'h0);
    chk(sfr_rdata_o, 16'h0000);
  endtask
  // low placement is in force until the instruction is seen
  task automatic t_low;
    logic [19:0] a [12] = '{20'h00000, 20'h0003f, 20'h00040, 20'h0007f, 20'h00800, 20'h00fff,
                            20'h0c000, 20'h0f6ff, 20'h0f700, 20'h0fd00, 20'h0fe80, 20'h10000};
    logic [9:0]  e [12] = '{10'h208, 10'h208, 10'h204, 10'h204, 10'h202, 10'h202,
                            10'h200, 10'h200, 10'h100, 10'h101, 10'h081, 10'h010};
    for (int i = 0; i < 12; i++) begin
      acc(a[i], 1'h0, 2'h1, 16'h0);
      chk({sel, vec_area_o, table_indexed_call_area_o, short_form_call_area_o, data_area_o}, e[i]);
    end
    ext_mode_en_i = 1'h1;
    acc(20'h10000, 1'h0, 2'h1, 16'h0);
    chk(sel, 6'h02);
    ext_mode_en_i = 1'h0;
    acc_vec_i = 1'h1;
    acc(20'h00010, 1'h0, 2'h1, 16'h0);
    chk({sel, vec_area_o}, 7'h41);
    acc_vec_i = 1'h0;
  endtask
  task automatic t_place;
    cyc;
    place_high_i = 1'h1;
    place_valid_i = 1'h1;
    cyc;
    place_valid_i = 1'h0;
    chk({placed_o, high_o, place_err_o}, 3'h6);
    cyc;
    place_high_i = 1'h0;
    place_valid_i = 1'h1;
    cyc;
    place_valid_i = 1'h0;
    chk({placed_o, high_o, place_err_o}, 3'h7);
    acc(20'h0f700, 1'h0, 2'h1, 16'h0);
    chk(sel, 6'h20);
    acc(20'h0ffff, 1'h0, 2'h1, 16'h0);
    chk(sel, 6'h20);
    chk(local_addr_o, 16'hffff);
    acc(20'hffd00, 1'h0, 2'h1, 16'h0);
    chk({sel, data_area_o}, 7'h21);
    chk(local_addr_o, 16'h0600);
    acc(20'hfff20, 1'h0, 2'h1, 16'h0);
    chk(sel, 6'h04);
  endtask
  task automatic t_sfr;
    acc(20'hfff20, 1'h1, 2'h1, 16'h005a);
    chk({sel, sfr_err_o}, 7'h08);
    acc(20'hfff20, 1'h0, 2'h1, 16'h0);
    chk(sfr_rdata_o, 16'h005a);
    acc(20'hfff02, 1'h1, 2'h1, 16'h0);
    chk(sfr_err_o, 1'h1);
    acc(20'hfff14, 1'h1, 2'h2, 16'hc3a5);
    chk(sfr_err_o, 1'h0);
    acc(20'hfff14, 1'h0, 2'h2, 16'h0);
    chk(sfr_rdata_o, 16'hc3a5);
    acc(20'hfff14, 1'h0, 2'h1, 16'h0);
    chk(sfr_rdata_o, 16'h00a5);
    acc(20'hfff15, 1'h0, 2'h1, 16'h0);
    chk(sfr_err_o, 1'h1);
    acc(20'hfff13, 1'h0, 2'h2, 16'h0);
    chk(sfr_err_o, 1'h1);
    acc(20'hfff10, 1'h1, 2'h0, 16'h0);
    chk(sfr_err_o, 1'h1);
    acc_bit_i = 3'h3;
    acc(20'hfff20, 1'h1, 2'h0, 16'h0);
    chk(sfr_err_o, 1'h0);
    acc(20'hfff20, 1'h0, 2'h1, 16'h0);
    chk(sfr_rdata_o, 16'h0052);
  endtask
  task automatic t_gpr;
    wr(4'h2, 1'h0, 16'h005a);
    wr(4'h4, 1'h1, 16'h1234);
    rd(4'h2, 1'h0);
    chk({gpr_rdata_o[7:0], gpr_ram_addr_o}, {8'h5a, 20'hffe82});
    rd(4'h4, 1'h1);
    chk(gpr_rdata_o, 16'h1234);
    rd(4'h5, 1'h0);
    chk(gpr_rdata_o[7:0], 8'h12);
    pw(16'h3000);
    rd(4'h2, 1'h0);
    chk({psw_o[15:12], gpr_ram_addr_o}, {4'h3, 20'hffeb2});
    cyc;
    ctx_bank_i = 3'h0;
    ctx_bank_we_i = 1'h1;
    cyc;
    ctx_bank_we_i = 1'h0;
    rd(4'h2, 1'h0);
    chk({psw_o, gpr_rdata_o[7:0]}, {16'h0000, 8'h5a});
    pw(16'h0020);
    alias_code_i = 3'h1;
    alias_en_i = 1'h1;
    rd(4'h0, 1'h0);
    chk(gpr_rdata_o[7:0], 8'h12);
    alias_code_i = 3'h4;
    rd(4'h0, 1'h0);
    chk(gpr_rdata_o, 16'h1234);
    alias_en_i = 1'h0;
    cyc;
    ext_wdata_i = 8'hab;
    ext_we_i = 1'h1;
    cyc;
    ext_we_i = 1'h0;
    wr(4'h8, 1'h1, 16'hbeef);
    cyc;
    chk(ptr_o, 24'habbeef);
  endtask
  task automatic t_pc;
    cyc;
    pc_val_i = 20'h12345;
    pc_load_i = 1'h1;
    cyc;
    pc_load_i = 1'h0;
    pc_step_i = 3'h3;
    chk(pc_o, 20'h12345);
    cyc;
    cyc;
    chk(pc_o, 20'h1234b);
    pc_step_i = 3'h0;
    sp_wdata_i = 24'h0ffe00;
    sp_we_i = 1'h1;
    cyc;
    sp_we_i = 1'h0;
    chk(sp_o, 24'h0ffe00);
  endtask
  // an empty special slot hangs the block until reset
  task automatic t_lock;
    acc(20'hfff08, 1'h0, 2'h1, 16'h0);
    chk(lockup_o, 1'h1);
    acc(20'hfff20, 1'h0, 2'h1, 16'h0);
    chk({sel, lockup_o}, 7'h01);
    cyc;
    reset_n_i = 1'h0;
    cyc;
    reset_n_i = 1'h1;
    chk({lockup_o, placed_o}, 2'h0);
  endtask
  // ------------
  // main
  // ------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'h1;
    t_reset;
    t_low;
    t_place;
    t_sfr;
    t_gpr;
    t_pc;
    t_lock;
    end_sim;
  end
endmodule
`default_nettype wire

// ### addr_map_defs.vh
`ifndef ADDR_MAP_DEFS_VH
`define ADDR_MAP_DEFS_VH

// ----------------------------------------------------------------------
// address map, offsets inside a 64-Kbyte segment
// ----------------------------------------------------------------------
`define AM_VEC_END        16'h003f
`define AM_TABLE_INDEXED_CALL_BASE     16'h0040
`define AM_TABLE_INDEXED_CALL_END      16'h007f
`define AM_SHORT_FORM_CALL_BASE     16'h0800
`define AM_SHORT_FORM_CALL_END      16'h0fff
`define AM_ROM48_END      16'hbfff
`define AM_ROM64_LOW_END  16'hf6ff
`define AM_ROM64_HIGH_END 16'hffff
`define AM_IDATA_BASE     16'hf700
`define AM_DATA_BASE      16'hfd00
`define AM_GPR_BASE       16'hfe80
`define AM_SFR_BASE       16'hff00
`define AM_SEG_LOW        4'h0
`define AM_SEG_HIGH       4'hf

// ----------------------------------------------------------------------
// access width codes
// ----------------------------------------------------------------------
`define AW_BIT            2'h0
`define AW_BYTE           2'h1
`define AW_WORD           2'h2

// ----------------------------------------------------------------------
// status word fields and reset values
// ----------------------------------------------------------------------
`define PSW_ALIAS_BIT     5
`define PSW_BANK_LSB      12
`define PSW_BANK_MSB      14
`define PSW_RST           16'h0000
`define PC_RST            20'h00000
`define SP_RST            24'h000000

// ----------------------------------------------------------------------
// special register reset values and init walk length
// ----------------------------------------------------------------------
`define SFR_RST_UNDEF     8'h00
`define SFR_RST_PM        8'hff
`define SFR_RST_CRC       8'h10
`define SFR_INIT_LAST     8'hff

`endif

// ### sfr_attr_table.v
`default_nettype none

// ----------------------------------------------------------------------
// special register attribute lookup: allocation, direction, widths,
// reset value for one window offset
// ----------------------------------------------------------------------
module sfr_attr_table (
  input  wire [7:0] off_i,
  output reg        alloc_o,
  output reg        rd_o,
  output reg        wr_o,
  output reg        bit_o,
  output reg        byte_o,
  output reg        word_o,
  output reg  [7:0] rst_o
);

  `include "addr_map_defs.vh"

  // defaults suit a plain read-write byte register; holes fall to default
  always @* begin
    alloc_o = 1'b1;
    rd_o    = 1'b1;
    wr_o    = 1'b1;
    bit_o   = 1'b0;
    byte_o  = 1'b1;
    word_o  = 1'b0;
    rst_o   = `SFR_RST_UNDEF;
    case (off_i)
      8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0e, 8'h0f,
      8'h2e, 8'h31: begin
        bit_o = 1'b1;
      end
      8'h02: begin
        bit_o = 1'b1;
        wr_o  = 1'b0;
      end
      8'h10, 8'h12: begin
        byte_o = 1'b0;
        word_o = 1'b1;
      end
      8'h14, 8'h16, 8'h1c: begin
        word_o = 1'b1;
      end
      // upper halves 11..17 and 1d reachable only through the word at the even address; 19 and 1b not at all
      8'h11, 8'h13, 8'h15, 8'h17, 8'h19, 8'h1b, 8'h1d: begin
        byte_o = 1'b0;
      end
      8'h18, 8'h1a, 8'h32: begin
        byte_o = 1'b1;
      end
      8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27: begin
        bit_o = 1'b1;
        rst_o = `SFR_RST_PM;
      end
      8'h30, 8'h33: begin
        rst_o = `SFR_RST_CRC;
      end
      default: begin
        alloc_o = 1'b0;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        byte_o  = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire
